// file: verilog/usp_pkg.sv
// Package for the universal serial port: register map, control layout,
// reset values, mode codes and bit timing shared by the design files.
// Assumes a 32-bit register port with byte addresses on aligned words.
`default_nettype none
package usp_pkg;
  // Register byte offsets
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_BAUD = 6'h04;
  localparam logic [5:0] OFS_FDIV = 6'h08;
  localparam logic [5:0] OFS_TXD  = 6'h0c;
  localparam logic [5:0] OFS_RXD  = 6'h10;
  localparam logic [5:0] OFS_STAT = 6'h14;
  localparam logic [5:0] OFS_CLR  = 6'h18;
  localparam logic [5:0] OFS_IEN  = 6'h1c;
  localparam logic [5:0] OFS_IRW  = 6'h20;
  localparam logic [5:0] OFS_LVL  = 6'h24;

  // Frame modes, in control bits [2:1]
  typedef enum logic [1:0] {
    USP_ASYNC8,
    USP_ASYNC9,
    USP_WAKE,
    USP_SYNC
  } usp_mode_t;

  // Control register layout, bit 0 at the bottom
  typedef struct packed {
    logic      abd_en;
    logic      sync_rx;
    logic      irda_prog;
    logic      irda;
    logic      loop;
    logic      frame_chk;
    logic      two_stop;
    logic      odd;
    logic      par_en;
    usp_mode_t mode;
    logic      en;
  } usp_ctrl_t;

  localparam int unsigned CTRL_W = 12;

  // Reset values
  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  localparam logic [8:0]  FDIV_RST = 9'h000;
  localparam logic [7:0]  IRW_RST  = 8'h10;
  localparam logic [7:0]  IEN_RST  = 8'h00;

  // Status bit positions
  localparam int unsigned ST_TBE = 0;
  localparam int unsigned ST_TXC = 1;
  localparam int unsigned ST_RXF = 2;
  localparam int unsigned ST_FE  = 3;
  localparam int unsigned ST_PE  = 4;
  localparam int unsigned ST_OE  = 5;
  localparam int unsigned ST_ABS = 6;
  localparam int unsigned ST_ABE = 7;
  localparam int unsigned NST    = 8;

  // Bit timing in oversample ticks: 16 per bit, sample at the middle
  localparam logic [3:0] OS_LAST  = 4'hf;
  localparam logic [3:0] OS_MID   = 4'h7;
  localparam logic [3:0] IRDA_FIX = 4'h2;
endpackage
`default_nettype wire

// file: verilog/usp_top.sv
// Universal serial port: async full duplex with parity, wake-up bit, IrDA and
// autobaud, or half-duplex synchronous with a driven shift clock; 8-entry FIFOs.
// Assumes rxd_i is asynchronous to clk; all other inputs are on clk.
//
// Overview of operation
// [R1] Async frame: start, 8 or 9 data bits incl. parity, one or two stops
// [R2] Async runs both directions at once; sync moves one direction at a time
// [R3] Wake-up mode carries 8 data bits plus a ninth address marker bit
// [R4] IrDA pulse coding up to 115.2 kbit/s, fixed or programmable width
// [R5] Sync mode shifts 8-bit bytes on a shift clock the port drives
// [R6] Sync mode shifts the least significant bit first
// [R7] Transmit and receive each pass an eight-entry FIFO
// [R8] Fractional divider ahead of the reload counter sets the bit rate
// [R9] Async rate programmable from 2.5 Mbit/s to 0.6 bit/s at 40 MHz; here down to about 0.075 bit/s
// [R10] Sync rate programmable from 5 Mbit/s to 406.9 bit/s at 40 MHz; here from 20 Mbit/s down to about 0.6 bit/s
// [R11] Autobaud measures a start bit, then loads rate and mode itself
// [R12] Parity inserted on transmit, checked on receive, error on mismatch
// [R13] Missing stop bit gives a framing error when checking is on
// [R14] Overrun when a character completes with the receive buffer full
// [R15] Four interrupt lines: transmit, receive, error, autobaud
// [R16] Interrupts on buffer empty, last bit, receive, errors, autobaud start/end
// [R17] Loop-back routes transmit output into the receiver
// [R18] Error flags stay set until cleared; reception goes on meanwhile
// [R19] Idle async line is high; start bit is low for one bit period
//
// Our own choices: the address-and-strobe port and the address map.
`default_nettype none

module usp_fifo #(
  parameter int unsigned W     = 9,
  parameter int unsigned DEPTH = 8,
  parameter int unsigned CW    = $clog2(DEPTH + 1)
) (
  // System
  input  wire logic          clk,
  input  wire logic          srst,
  // Fill side
  input  wire logic          push,
  input  wire logic [W-1:0]  din,
  output logic               full,
  // Drain side
  input  wire logic          pop,
  output logic [W-1:0]       dout,
  output logic               empty,
  output logic [CW-1:0]      count
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wp;
  logic [PW-1:0] rp;
  logic [PW-1:0] next_wp;
  logic [PW-1:0] next_rp;
  logic [CW-1:0] next_count;
  logic          do_push;
  logic          do_pop;

  always_comb begin
    do_push    = push && !full;
    do_pop     = pop && !empty;
    next_wp    = do_push ? ((wp == PW'(DEPTH - 1)) ? '0 : wp + 1'b1) : wp;
    next_rp    = do_pop ? ((rp == PW'(DEPTH - 1)) ? '0 : rp + 1'b1) : rp;
    next_count = count + CW'(do_push) - CW'(do_pop);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wp    <= '0;
      rp    <= '0;
      count <= '0;
    end else begin
      wp    <= next_wp;
      rp    <= next_rp;
      count <= next_count;
    end
    // Storage needs no reset; only the pointers define what is valid
    if (do_push) begin
      mem[wp] <= din;
    end
  end

  assign full  = (count == CW'(DEPTH));
  assign empty = (count == '0);
  assign dout  = mem[rp];
endmodule

module usp_top #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned CW    = $clog2(DEPTH + 1)
) (
  // System
  input  wire logic        clk,
  input  wire logic        srst,
  // Register port
  input  wire logic [5:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Serial pins: txd is async data or sync shift clock
  output logic             txd,
  input  wire logic        rxd_i,
  output logic             rxd_o,
  output logic             rxd_oe,
  // Interrupt lines
  output logic             irq_tx,
  output logic             irq_rx,
  output logic             irq_err,
  output logic             irq_abd
);
  typedef enum {R_IDLE, R_START, R_DATA, R_STOP} usp_rx_st_t;
  typedef enum {T_IDLE, T_START, T_DATA, T_STOP, T_SYNC} usp_tx_st_t;

  usp_pkg::usp_ctrl_t ctrl, next_ctrl;
  logic [15:0] baud, next_baud;
  logic [8:0]  fdiv, next_fdiv;
  logic [7:0]  irw, next_irw;
  logic [7:0]  ien, next_ien;
  logic [7:0]  status, next_status;
  logic [31:0] next_rdata;
  logic        next_irq_tx, next_irq_rx, next_irq_err, next_irq_abd;
  logic        abd_busy, next_abd_busy;
  logic [19:0] abd_cnt, next_abd_cnt;
  logic [7:0]  st_set;

  // Baud generation
  logic [8:0]  frac, next_frac;
  logic [15:0] rcnt, next_rcnt;
  logic        os_tick;
  logic [9:0]  frac_sum;
  logic        pre_tick;

  // Receive path
  logic        rxd_s1, rxd_s2;
  logic        rx_src, rx_line, rx_line_q;
  logic        ir_hold, next_ir_hold;
  logic [3:0]  ir_cnt, next_ir_cnt;
  usp_rx_st_t  rst_q, next_rst;
  logic [3:0]  r_tick, next_r_tick;
  logic [3:0]  r_bit, next_r_bit;
  logic [8:0]  r_sh, next_r_sh;
  logic [8:0]  r_data;
  logic        a_done, a_fe, a_pe;
  logic        nd9;

  // Transmit path
  usp_tx_st_t  tst, next_tst;
  logic [3:0]  t_tick, next_t_tick;
  logic [3:0]  t_bit, next_t_bit;
  logic [8:0]  t_sh, next_t_sh;
  logic [7:0]  t_clk, next_t_clk;
  logic        next_txd, next_rxd_o, next_rxd_oe;
  logic        t_bitval, s_done, t_fin, tx_pop;
  logic [8:0]  t_frame;
  logic        t_par;

  // FIFOs
  logic          tx_full, tx_empty, rx_full, rx_empty, rx_push, rx_pop;
  logic [8:0]    tx_dout, rx_dout, rx_din;
  logic [CW-1:0] tx_cnt, rx_cnt;
  logic          tx_wr;

  assign tx_wr = reg_wr && (reg_addr == usp_pkg::OFS_TXD);
  assign rx_pop = reg_rd && (reg_addr == usp_pkg::OFS_RXD);

  usp_fifo #(.W(9), .DEPTH(DEPTH), .CW(CW)) u_txf ( // see [R7]
    .clk(clk), .srst(srst), .push(tx_wr), .din(reg_wdata[8:0]), .full(tx_full),
    .pop(tx_pop), .dout(tx_dout), .empty(tx_empty), .count(tx_cnt));
  usp_fifo #(.W(9), .DEPTH(DEPTH), .CW(CW)) u_rxf ( // see [R7]
    .clk(clk), .srst(srst), .push(rx_push), .din(rx_din), .full(rx_full),
    .pop(rx_pop), .dout(rx_dout), .empty(rx_empty), .count(rx_cnt));

  // Baud generator: fractional step then reload count, one tick per 1/16 async bit or per half sync bit
  always_comb begin
    frac_sum  = {1'b0, frac} + {1'b0, fdiv};
    pre_tick  = (fdiv == '0) ? 1'b1 : frac_sum[9]; // see [R8]
    next_frac = (fdiv == '0) ? frac : frac_sum[8:0];
    os_tick   = pre_tick && (rcnt == '0);
    next_rcnt = rcnt;
    if (pre_tick) begin
      next_rcnt = (rcnt == '0) ? baud : rcnt - 1'b1; // see [R9] [R10]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      frac <= '0;
      rcnt <= '0;
    end else begin
      frac <= next_frac;
      rcnt <= next_rcnt;
    end
  end

  // Receive path: loop-back, IrDA pulse stretch, async framing
  always_comb begin
    rx_src       = ctrl.loop ? txd : rxd_s2; // see [R17]
    rx_line      = ctrl.irda ? !ir_hold : rx_src;
    nd9          = (ctrl.mode != usp_pkg::USP_ASYNC8);
    next_ir_hold = ir_hold;
    next_ir_cnt  = ir_cnt;
    // A pulse marks a zero bit; hold the line low for one bit time
    if (rx_src) begin
      next_ir_hold = 1'b1; // see [R4]
      next_ir_cnt  = '0;
    end else if (ir_hold && os_tick) begin
      next_ir_cnt  = ir_cnt + 1'b1;
      next_ir_hold = (ir_cnt != usp_pkg::OS_LAST);
    end
    next_rst    = rst_q;
    next_r_tick = r_tick;
    next_r_bit  = r_bit;
    next_r_sh   = r_sh;
    r_data      = nd9 ? r_sh : {1'b0, r_sh[8:1]};
    a_done      = 1'b0;
    a_fe        = 1'b0;
    a_pe        = 1'b0;
    case (rst_q)
      R_IDLE: begin
        if (ctrl.en && ctrl.mode != usp_pkg::USP_SYNC && !abd_busy && !ctrl.abd_en &&
            rx_line_q && !rx_line) begin
          next_rst    = R_START;
          next_r_tick = '0;
        end
      end
      R_START: begin
        if (os_tick) begin
          next_r_tick = r_tick + 1'b1;
          if (r_tick == usp_pkg::OS_MID) begin
            next_rst    = rx_line ? R_IDLE : R_DATA;
            next_r_tick = '0;
            next_r_bit  = '0;
          end
        end
      end
      R_DATA: begin
        if (os_tick) begin
          next_r_tick = r_tick + 1'b1;
          if (r_tick == usp_pkg::OS_LAST) begin
            next_r_sh  = {rx_line, r_sh[8:1]}; // see [R1]
            next_r_bit = r_bit + 1'b1;
            if (r_bit == (nd9 ? 4'h8 : 4'h7)) begin
              next_rst = R_STOP;
            end
          end
        end
      end
      R_STOP: begin
        if (os_tick) begin
          next_r_tick = r_tick + 1'b1;
          if (r_tick == usp_pkg::OS_LAST) begin
            a_done   = 1'b1;
            a_fe     = ctrl.frame_chk && !rx_line; // see [R13]
            a_pe     = ctrl.par_en && ((^r_data) != ctrl.odd); // see [R12]
            next_rst = R_IDLE;
          end
        end
      end
      default: next_rst = R_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rxd_s1    <= 1'b1;
      rxd_s2    <= 1'b1;
      rx_line_q <= 1'b1;
      ir_hold   <= 1'b0;
      ir_cnt    <= '0;
      rst_q     <= R_IDLE;
      r_tick    <= '0;
      r_bit     <= '0;
      r_sh      <= '0;
    end else begin
      rxd_s1    <= rxd_i;
      rxd_s2    <= rxd_s1;
      rx_line_q <= rx_line;
      ir_hold   <= next_ir_hold;
      ir_cnt    <= next_ir_cnt;
      rst_q     <= next_rst;
      r_tick    <= next_r_tick;
      r_bit     <= next_r_bit;
      r_sh      <= next_r_sh;
    end
  end

  // Transmit path: async frames, IrDA pulses, sync shift clock
  always_comb begin
    t_par   = ctrl.odd ^ (nd9 ? ^tx_dout[7:0] : ^tx_dout[6:0]);
    t_frame = tx_dout;
    if (ctrl.par_en) begin
      t_frame = nd9 ? {t_par, tx_dout[7:0]} : {1'b0, t_par, tx_dout[6:0]}; // see [R12]
    end
    next_tst    = tst;
    next_t_tick = t_tick;
    next_t_bit  = t_bit;
    next_t_sh   = t_sh;
    tx_pop      = 1'b0;
    s_done      = 1'b0;
    t_fin       = 1'b0;
    t_bitval    = 1'b1; // see [R19]
    case (tst)
      T_IDLE: begin
        if (ctrl.en && !tx_empty && !abd_busy) begin
          tx_pop      = 1'b1;
          next_t_tick = '0;
          next_t_bit  = '0;
          next_t_sh   = t_frame;
          next_tst    = (ctrl.mode == usp_pkg::USP_SYNC) ? T_SYNC : T_START;
        end
      end
      T_START: begin
        t_bitval = 1'b0; // see [R19]
        if (os_tick) begin
          next_t_tick = t_tick + 1'b1;
          if (t_tick == usp_pkg::OS_LAST) begin
            next_tst = T_DATA;
          end
        end
      end
      T_DATA: begin
        t_bitval = t_sh[0]; // see [R1] [R3]
        if (os_tick) begin
          next_t_tick = t_tick + 1'b1;
          if (t_tick == usp_pkg::OS_LAST) begin
            next_t_sh  = {1'b0, t_sh[8:1]};
            next_t_bit = t_bit + 1'b1;
            if (t_bit == (nd9 ? 4'h8 : 4'h7)) begin
              next_tst   = T_STOP;
              next_t_bit = '0;
            end
          end
        end
      end
      T_STOP: begin
        if (os_tick) begin
          next_t_tick = t_tick + 1'b1;
          if (t_tick == usp_pkg::OS_LAST) begin
            next_t_bit = t_bit + 1'b1;
            if (!ctrl.two_stop || t_bit == 4'h1) begin // see [R1]
              next_tst = T_IDLE;
              t_fin    = 1'b1;
            end
          end
        end
      end
      T_SYNC: begin
        // Even phase: clock low, data set up; odd phase: clock high, sample
        if (os_tick) begin
          next_t_tick = t_tick + 1'b1;
          if (!t_tick[0] && ctrl.sync_rx) begin
            next_t_sh = {1'b0, rxd_s2, t_sh[7:1]}; // see [R6]
          end else if (t_tick[0] && !ctrl.sync_rx) begin
            next_t_sh = {1'b0, t_sh[8:1]}; // see [R6]
          end
          if (t_tick == usp_pkg::OS_LAST) begin // see [R5]
            next_tst = T_IDLE;
            t_fin    = 1'b1;
            s_done   = ctrl.sync_rx;
          end
        end
      end
      default: next_tst = T_IDLE;
    endcase
    // Clock count since bit start drives the programmable IrDA width
    next_t_clk = (os_tick && t_tick == usp_pkg::OS_LAST) ? '0 :
                 (t_clk == 8'hff) ? t_clk : t_clk + 1'b1;
    if (tst == T_SYNC) begin
      next_txd    = t_tick[0]; // see [R5]
      next_rxd_o  = t_sh[0];
      next_rxd_oe = !ctrl.sync_rx; // see [R2]
    end else if (ctrl.irda) begin
      next_txd    = !t_bitval && (ctrl.irda_prog ? (t_clk < irw) :
                                  (t_tick <= usp_pkg::IRDA_FIX)); // see [R4]
      next_rxd_o  = 1'b0;
      next_rxd_oe = 1'b0;
    end else begin
      next_txd    = t_bitval;
      next_rxd_o  = 1'b0;
      next_rxd_oe = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tst    <= T_IDLE;
      t_tick <= '0;
      t_bit  <= '0;
      t_sh   <= '0;
      t_clk  <= '0;
      txd    <= 1'b1;
      rxd_o  <= 1'b0;
      rxd_oe <= 1'b0;
    end else begin
      tst    <= next_tst;
      t_tick <= next_t_tick;
      t_bit  <= next_t_bit;
      t_sh   <= next_t_sh;
      t_clk  <= next_t_clk;
      txd    <= next_txd;
      rxd_o  <= next_rxd_o;
      rxd_oe <= next_rxd_oe;
    end
  end

  // Received characters: async has priority over sync, mode change only
  assign rx_push = a_done || s_done;
  assign rx_din  = a_done ? r_data : {1'b0, t_sh[7:0]};

  // Register file, status, autobaud and interrupt lines
  always_comb begin
    next_ctrl     = ctrl;
    next_baud     = baud;
    next_fdiv     = fdiv;
    next_irw      = irw;
    next_ien      = ien;
    next_abd_busy = abd_busy;
    next_abd_cnt  = abd_cnt;
    st_set        = '0;
    st_set[usp_pkg::ST_TBE] = tx_pop && (tx_cnt == CW'(1));
    st_set[usp_pkg::ST_TXC] = t_fin;
    st_set[usp_pkg::ST_RXF] = rx_push && !rx_full;
    st_set[usp_pkg::ST_FE]  = a_fe;
    st_set[usp_pkg::ST_PE]  = a_pe;
    st_set[usp_pkg::ST_OE]  = rx_push && rx_full; // see [R14]
    if (reg_wr) begin
      if (reg_addr == usp_pkg::OFS_CTRL) begin
        next_ctrl = usp_pkg::usp_ctrl_t'(reg_wdata[usp_pkg::CTRL_W-1:0]);
      end else if (reg_addr == usp_pkg::OFS_BAUD) begin
        next_baud = reg_wdata[15:0];
      end else if (reg_addr == usp_pkg::OFS_FDIV) begin
        next_fdiv = reg_wdata[8:0];
      end else if (reg_addr == usp_pkg::OFS_IEN) begin
        next_ien = reg_wdata[7:0];
      end else if (reg_addr == usp_pkg::OFS_IRW) begin
        next_irw = reg_wdata[7:0];
      end
    end
    // Autobaud times the start bit of a character whose first data bit is one
    if (!abd_busy && ctrl.abd_en && rx_line_q && !rx_line) begin
      next_abd_busy = 1'b1;
      next_abd_cnt  = '0;
      st_set[usp_pkg::ST_ABS] = 1'b1; // see [R16]
    end else if (abd_busy && (!rx_line_q || !rx_line)) begin
      next_abd_cnt = (abd_cnt == 20'hfffff) ? abd_cnt : abd_cnt + 1'b1;
    end else if (abd_busy) begin
      next_abd_busy      = 1'b0;
      next_baud          = (abd_cnt[19:4] == '0) ? '0 : abd_cnt[19:4] - 1'b1; // see [R11]
      next_fdiv          = '0;
      next_ctrl.mode     = usp_pkg::USP_ASYNC8;
      next_ctrl.par_en   = 1'b0;
      next_ctrl.two_stop = 1'b0;
      next_ctrl.irda     = 1'b0;
      next_ctrl.abd_en   = 1'b0;
      next_ctrl.en       = 1'b1;
      st_set[usp_pkg::ST_ABE] = 1'b1;
    end
    // A new event wins over a clear in the same cycle; flags hold until cleared
    next_status = status | st_set; // see [R16] [R18]
    if (reg_wr && reg_addr == usp_pkg::OFS_CLR) begin
      next_status = (status & ~reg_wdata[7:0]) | st_set;
    end
    next_irq_tx  = |(next_status[1:0] & next_ien[1:0]); // see [R15]
    next_irq_rx  = next_status[usp_pkg::ST_RXF] && next_ien[usp_pkg::ST_RXF];
    next_irq_err = |(next_status[5:3] & next_ien[5:3]);
    next_irq_abd = |(next_status[7:6] & next_ien[7:6]);
    next_rdata   = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == usp_pkg::OFS_CTRL) begin
        next_rdata = 32'(ctrl);
      end else if (reg_addr == usp_pkg::OFS_BAUD) begin
        next_rdata = 32'(baud);
      end else if (reg_addr == usp_pkg::OFS_FDIV) begin
        next_rdata = 32'(fdiv);
      end else if (reg_addr == usp_pkg::OFS_RXD) begin
        next_rdata = rx_empty ? 32'h0000_0000 : 32'(rx_dout);
      end else if (reg_addr == usp_pkg::OFS_STAT) begin
        next_rdata = 32'(status);
      end else if (reg_addr == usp_pkg::OFS_IEN) begin
        next_rdata = 32'(ien);
      end else if (reg_addr == usp_pkg::OFS_IRW) begin
        next_rdata = 32'(irw);
      end else if (reg_addr == usp_pkg::OFS_LVL) begin
        next_rdata = {10'h000, abd_busy, tst != T_IDLE, rst_q != R_IDLE,
                      rx_full, tx_full, rx_empty, 8'(tx_cnt), 8'(rx_cnt)};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl      <= usp_pkg::usp_ctrl_t'(usp_pkg::CTRL_RST);
      baud      <= usp_pkg::BAUD_RST;
      fdiv      <= usp_pkg::FDIV_RST;
      irw       <= usp_pkg::IRW_RST;
      ien       <= usp_pkg::IEN_RST;
      status    <= '0;
      abd_busy  <= 1'b0;
      abd_cnt   <= '0;
      reg_rdata <= '0;
      irq_tx    <= 1'b0;
      irq_rx    <= 1'b0;
      irq_err   <= 1'b0;
      irq_abd   <= 1'b0;
    end else begin
      ctrl      <= next_ctrl;
      baud      <= next_baud;
      fdiv      <= next_fdiv;
      irw       <= next_irw;
      ien       <= next_ien;
      status    <= next_status;
      abd_busy  <= next_abd_busy;
      abd_cnt   <= next_abd_cnt;
      reg_rdata <= next_rdata;
      irq_tx    <= next_irq_tx;
      irq_rx    <= next_irq_rx;
      irq_err   <= next_irq_err;
      irq_abd   <= next_irq_abd;
    end
  end
endmodule
`default_nettype wire

// file: sim/usp_monitor.sv
// Checker for the serial port top: register port, line and interrupt relations.
// Assumes it is bound to usp_top and that autobaud is left off while it watches.
`default_nettype none
module usp_monitor (
  // System
  input wire logic        clk,
  input wire logic        srst,
  // Register port
  input wire logic [5:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Pins and interrupts
  input wire logic        txd,
  input wire logic        rxd_oe,
  input wire logic        irq_tx,
  input wire logic        irq_rx,
  input wire logic        irq_err,
  input wire logic        irq_abd
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shadows follow software writes only; autobaud rewrites would be invisible
  logic [11:0] cm;
  logic [7:0]  ien;
  logic        b0;
  logic        asy;
  always_ff @(posedge clk) begin
    if (srst) begin
      cm  <= usp_pkg::CTRL_RST;
      ien <= usp_pkg::IEN_RST;
      b0  <= 1'b1;
    end else if (reg_wr) begin
      if (reg_addr == usp_pkg::OFS_CTRL) cm <= reg_wdata[11:0];
      if (reg_addr == usp_pkg::OFS_IEN) ien <= reg_wdata[7:0];
      if (reg_addr == usp_pkg::OFS_BAUD) b0 <= reg_wdata[15:0] == 16'h0;
    end
  end
  assign asy = cm[0] && cm[2:1] != 2'd3 && !cm[8] && !cm[11] && b0;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_reset_idle: assert property ($fell(srst) |-> txd && !rxd_oe && !irq_tx && !irq_rx
    && !irq_err && !irq_abd && reg_rdata == 32'h0) else $error("outputs not idle");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_rd_unmapped: assert property (reg_rd && reg_addr > 6'h24 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_readback: assert property (reg_rd && reg_addr == usp_pkg::OFS_CTRL && !cm[11]
    |=> reg_rdata == {20'h0, cm}) else $error("control readback wrong");
  a_start_len: assert property (
    asy && $fell(txd) |-> (!txd)[*8] ##1 (!txd)[*8]) else $error("start bit short");
  a_sync_drive: assert property (
    rxd_oe |-> cm[2:1] == 2'd3) else $error("data pin driven outside sync");
  a_rx_irq_mask: assert property (
    irq_rx |-> ien[2]) else $error("receive line while masked");
  a_err_irq_mask: assert property (
    irq_err |-> |ien[5:3]) else $error("error line while masked");

  c_async_frame: cover property (asy && $fell(txd));
  c_err_irq: cover property (irq_err);
  c_rx_irq: cover property (irq_rx);
  c_sync: cover property (rxd_oe);
endmodule

bind usp_top usp_monitor usp_monitor_i (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .txd, .rxd_oe, .irq_tx, .irq_rx, .irq_err, .irq_abd);
`default_nettype wire

// file: sim/usp_peer.sv
// Far-end station: sends async frames on the receive line, decodes the
// port's async frames and sync bytes. Assumes BAUD and FDIV at zero.
`default_nettype none
module usp_peer (
  // System
  input wire logic clk,
  // Pins
  input wire logic txd,
  input wire logic line,
  output logic     rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pulled-up line, so idle reads high
  initial rxd = 1'b1;

  // Start bit, then nb bits LSB first, then a full stop bit
  task automatic put(input logic [9:0] bits, input int nb);
    rxd <= 1'b0;
    repeat (16) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      rxd <= bits[i];
      repeat (16) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (16) @(posedge clk);
  endtask

  // Mid-bit sampling; ok drops on a missing start or stop bit
  task automatic get(output logic [7:0] d, output logic ok);
    int n;
    d = 8'h00;
    for (n = 0; n < 3000 && txd !== 1'b0; n++) @(posedge clk);
    repeat (8) @(posedge clk);
    ok = txd === 1'b0;
    for (n = 0; n < 8; n++) begin
      repeat (16) @(posedge clk);
      d[n] = txd;
    end
    repeat (16) @(posedge clk);
    ok = ok && txd === 1'b1;
  endtask

  // Sync byte: data taken while the shift clock is high
  task automatic sget(output logic [7:0] d);
    int n;
    d = 8'h00;
    for (int i = 0; i < 8; i++) begin
      for (n = 0; n < 500 && txd !== 1'b0; n++) @(posedge clk);
      for (n = 0; n < 500 && txd !== 1'b1; n++) @(posedge clk);
      d[i] = line;
    end
  endtask
endmodule
`default_nettype wire

// file: sim/usp_top_tb.sv
// Self-checking bench for the serial port: register tasks, a far-end station
// on the pins, scenario sequences. Assumes BAUD and FDIV stay at reset.
`default_nettype none
module usp_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [5:0]  reg_addr = 6'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        txd, rxd, rxd_o, rxd_oe;
  logic        irq_tx, irq_rx, irq_err;
  logic [7:0]  d;
  logic        ok;
  int          n_mismatch = 0;
  int          checks = 0;
  // Shared data pin: whoever enables drives it
  wire         rxd_w = rxd_oe ? rxd_o : rxd;

  always #5 clk = ~clk;

  usp_top usp_top_i (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .txd, .rxd_i(rxd_w), .rxd_o, .rxd_oe, .irq_tx, .irq_rx, .irq_err, .irq_abd());
  usp_peer usp_peer_i (.clk, .txd, .line(rxd_w), .rxd);

  task automatic summarize();
    if (n_mismatch == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata & m, e);
    @(posedge clk);
  endtask

  task automatic rx(input logic [7:0] e);
    usp_peer_i.get(d, ok);
    if (ok !== 1'b1) begin
      n_mismatch++;
      summarize();
    end else chk({24'h0, d}, {24'h0, e});
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    summarize();
  end

  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(usp_pkg::OFS_CTRL, 32'h0);
    rd(usp_pkg::OFS_IRW, 32'h10);
    rd(6'h3c, 32'h0);
    rd(usp_pkg::OFS_CLR, 32'h0);
    // Back-to-back characters, even parity lands in bit 7
    wr(usp_pkg::OFS_IEN, 32'hff);
    wr(usp_pkg::OFS_CTRL, 32'h009);
    rd(usp_pkg::OFS_CTRL, 32'h009);
    wr(usp_pkg::OFS_TXD, 32'h35);
    wr(usp_pkg::OFS_TXD, 32'h07);
    rx(8'h35);
    rx(8'h87);
    repeat (20) @(posedge clk);
    rd(usp_pkg::OFS_STAT, 32'h03);
    chk({31'h0, irq_tx}, 32'h1);
    wr(usp_pkg::OFS_CLR, 32'hff);
    rd(usp_pkg::OFS_STAT, 32'h0);
    chk({31'h0, irq_tx}, 32'h0);
    wr(usp_pkg::OFS_CTRL, 32'h001);
    usp_peer_i.put(10'h13c, 9);
    rd(usp_pkg::OFS_RXD, 32'h3c);
    rd(usp_pkg::OFS_STAT, 32'h04);
    chk({31'h0, irq_rx}, 32'h1);
    // Bad parity, missing stop, then a good one while both flags stand
    wr(usp_pkg::OFS_CLR, 32'hff);
    wr(usp_pkg::OFS_CTRL, 32'h049);
    usp_peer_i.put(10'h1b5, 9);
    usp_peer_i.put(10'h087, 9);
    usp_peer_i.put(10'h135, 9);
    rd(usp_pkg::OFS_STAT, 32'h1c);
    chk({31'h0, irq_err}, 32'h1);
    for (int i = 0; i < 3; i++) rd(usp_pkg::OFS_RXD, 32'h0, 32'h0);
    // Nine characters into eight places
    wr(usp_pkg::OFS_CLR, 32'hff);
    wr(usp_pkg::OFS_CTRL, 32'h001);
    for (int i = 0; i < 9; i++) usp_peer_i.put({2'b01, 8'(i)}, 9);
    rd(usp_pkg::OFS_LVL, 32'h40008);
    rd(usp_pkg::OFS_STAT, 32'h24);
    rd(usp_pkg::OFS_RXD, 32'h0);
    wr(usp_pkg::OFS_CTRL, 32'h007);
    wr(usp_pkg::OFS_TXD, 32'ha5);
    usp_peer_i.sget(d);
    chk({24'h0, d}, 32'ha5);
    chk({31'h0, irq_err}, 32'h1);
    wr(usp_pkg::OFS_IEN, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq_err}, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
